/* ifs_pkg.sv */
// Purpose: constants and types for the in-system flash programming sequencer
// Assumes: one machine cycle equals one clk_sys cycle; special-function bus is byte wide
// Notes:   non-volatile option bits arrive as a plain input byte
// Summary of operation
// - main bank 64 KB holds application, loader bank 4 KB holds loader code.
// - chip control is read-only after reset; writing 87h then 59h unlocks it.
// - any other value written to the unlock register withdraws write permission.
// - second unlock value within three cycles; window then open three cycles.
// - the unlock register sits at special-function address F6h.
// - chip control bit 0 enters programming mode at next idle wake-up.
// - on wake-up fetch loader bank, clear PC, stack 0000h, run loader ISR.
// - first interrupt return in programming mode continues at loader address 00h; the code only tracks it in a flag and drives no output.
// - writing bits 0, 1 and 7 together resets the CPU back to main bank.
// - two byte registers hold the high and low flash address bytes.
// - data register carries program byte in and read byte out.
// - control bit 6 selects target bank, 0 main, 1 loader; bit 7 reserved.
// - control bit 5 output enable, bit 4 chip enable, bits 3..0 opcode.
// - erase uses opcode 0010, output enable 1, chip enable 0; address ignored.
// - program uses opcode 0001, output enable 1, chip enable 0, address and data.
// - read uses opcode 0000, output enable 0, chip enable 0; data returned.
// - after power-on boot from main bank unless loader-boot straps are present.
// - loader boot if both port-2 straps low with option bit 4 low, or port-4 strap and bit 5.
// - lock option bit 0 refuses all flash and option access.
// - table-read restriction bit 1 low keeps external-fetched table reads external.
// - encryption bit encodes port 0 data; cleared only by whole-chip erase.
// - option bit 7 zero halves oscillator amplifier gain.
package ifs_pkg;
	// ****************************************************************
	// register addresses
	// ****************************************************************
	localparam logic [7:0] ADDR_CHIP_CONTROL  = 8'h87;
	localparam logic [7:0] ADDR_WRITE_UNLOCK  = 8'hF6;
	localparam logic [7:0] ADDR_FLASH_CONTROL = 8'hC7;
	localparam logic [7:0] ADDR_FLASH_ADDR_HI = 8'hC6;
	localparam logic [7:0] ADDR_FLASH_ADDR_LO = 8'hC5;
	localparam logic [7:0] ADDR_FLASH_DATA    = 8'hC4;
	// ****************************************************************
	// unlock sequence and timing
	// ****************************************************************
	localparam logic [7:0] UNLOCK_FIRST  = 8'h87;
	localparam logic [7:0] UNLOCK_SECOND = 8'h59;
	localparam int unsigned UNLOCK_CYCLES = 3;
	localparam int unsigned BUSY_CYCLES   = 4;
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int unsigned CC_ISP_BIT    = 0;
	localparam int unsigned CC_SWR_A_BIT  = 1;
	localparam int unsigned CC_SWR_B_BIT  = 7;
	localparam int unsigned FC_BANK_BIT   = 6;
	localparam int unsigned FC_OE_BIT     = 5;
	localparam int unsigned FC_CE_BIT     = 4;
	localparam int unsigned OPT_LOCK_BIT  = 0;
	localparam int unsigned OPT_TRD_BIT   = 1;
	localparam int unsigned OPT_ENC_BIT   = 2;
	localparam int unsigned OPT_BOOTA_BIT = 4;
	localparam int unsigned OPT_BOOTB_BIT = 5;
	localparam int unsigned OPT_GAIN_BIT  = 7;
	localparam logic [3:0] OP_READ    = 4'h0;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_ERASE   = 4'h2;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] LOADER_VECTOR = 16'h0000;
	localparam int unsigned MAIN_ADDR_W   = 16;
	localparam int unsigned LOADER_ADDR_W = 12;

	typedef enum logic [1:0] {ULK_IDLE, ULK_ARMED, ULK_OPEN} ifs_ulk_t;
	typedef enum logic [1:0] {FL_IDLE, FL_BUSY} ifs_fl_t;
endpackage

/* ifs_sequencer.sv */
// Purpose: unlock, programming-mode entry, software reset and flash command sequencing
// Assumes: sfr bus writes and reads take one cycle; flash array answers via done pulse
// Notes:   all state lives in one packed struct
`timescale 1ns/1ps
module ifs_sequencer
	import ifs_pkg::*;
#(
	parameter int unsigned BUSY_MIN = BUSY_CYCLES
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// special-function bus
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	output logic            sfr_hit,
	// cpu status and control
	input  wire logic       cpu_idle_wake,
	input  wire logic       cpu_interrupt_return_instr,
	output logic            cpu_hold,
	output logic            cpu_soft_reset,
	output logic            cpu_fetch_loader,
	output logic            cpu_pc_clear,
	output logic            cpu_push_vector,
	output logic     [15:0] cpu_vector,
	// straps and option bits
	input  wire logic       boot_strap_a,
	input  wire logic       boot_strap_b,
	input  wire logic       boot_strap_c,
	input  wire logic [7:0] option_bits,
	input  wire logic       fetch_external,
	output logic            table_read_internal_ok,
	output logic            port0_encrypt,
	output logic            osc_half_gain,
	// flash array
	output logic            flash_start,
	output logic            target_bank_select,
	output logic            flash_output_enable,
	output logic            flash_chip_enable,
	output logic      [3:0] flash_op,
	output logic     [15:0] flash_addr,
	output logic      [7:0] flash_wdata,
	input  wire logic [7:0] flash_rdata,
	input  wire logic       flash_done
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		ifs_ulk_t    ulk;
		logic [1:0]  ulk_cnt;
		logic [7:0]  chip_control_reg;
		logic [7:0]  isp_flash_control;
		logic [7:0]  isp_flash_addr_high;
		logic [7:0]  isp_flash_addr_low;
		logic [7:0]  isp_flash_data;
		ifs_fl_t     fl;
		logic [7:0]  busy_cnt;
		logic        start;
		logic        isp_mode;
		logic        loader_exec;
		logic        first_interrupt_return_instr;
		logic        wake_pulse;
		logic        soft_reset;
		logic        boot_sampled;
		logic [7:0]  rdata;
		logic        hit;
	} ifs_state_t;

	ifs_state_t s_q;
	ifs_state_t s_d;

	function automatic logic wr_at(input logic [7:0] a);
		wr_at = sfr_wr && (sfr_addr == a);
	endfunction

	logic locked;
	logic loader_boot;
	logic wr_ok;
	assign locked = ~option_bits[OPT_LOCK_BIT];
	assign loader_boot = (~boot_strap_a & ~boot_strap_b & ~option_bits[OPT_BOOTA_BIT])
		| (~boot_strap_c & ~option_bits[OPT_BOOTB_BIT]);
	// flash registers can only be written while no operation runs
	assign wr_ok = (s_q.fl == FL_IDLE) && !locked;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_d            = s_q;
		s_d.start      = 1'b0;
		s_d.wake_pulse = 1'b0;
		s_d.soft_reset = 1'b0;
		s_d.hit        = 1'b0;
		s_d.rdata      = RESET_BYTE;
		// boot choice caught once, after reset release
		if (!s_q.boot_sampled) begin
			s_d.boot_sampled = 1'b1;
			s_d.loader_exec  = loader_boot;
		end
		// unlock sequencer
		case (s_q.ulk)
			ULK_ARMED: begin
				if (s_q.ulk_cnt == 2'(UNLOCK_CYCLES - 1)) begin
					s_d.ulk = ULK_IDLE;
				end else begin
					s_d.ulk_cnt = s_q.ulk_cnt + 2'd1;
				end
			end
			ULK_OPEN: begin
				if (s_q.ulk_cnt == 2'(UNLOCK_CYCLES - 1)) begin
					s_d.ulk = ULK_IDLE;
				end else begin
					s_d.ulk_cnt = s_q.ulk_cnt + 2'd1;
				end
			end
			default: s_d.ulk = ULK_IDLE;
		endcase
		if (wr_at(ADDR_WRITE_UNLOCK)) begin
			s_d.ulk_cnt = 2'd0;
			if (sfr_wdata == UNLOCK_FIRST) begin
				s_d.ulk = ULK_ARMED;
			end else if (sfr_wdata == UNLOCK_SECOND && s_q.ulk == ULK_ARMED) begin
				s_d.ulk = ULK_OPEN;
			end else begin
				s_d.ulk = ULK_IDLE;
			end
		end
		// chip control, writable only inside the window
		if (wr_at(ADDR_CHIP_CONTROL) && s_q.ulk == ULK_OPEN) begin
			if (sfr_wdata[CC_ISP_BIT] && sfr_wdata[CC_SWR_A_BIT]
				&& sfr_wdata[CC_SWR_B_BIT]) begin
				s_d.soft_reset       = 1'b1;
				s_d.isp_mode         = 1'b0;
				s_d.loader_exec      = 1'b0;
				s_d.chip_control_reg = RESET_BYTE;
			end else begin
				s_d.chip_control_reg = sfr_wdata;
			end
		end
		// programming mode entry is deferred to the idle wake-up
		if (cpu_idle_wake && s_q.chip_control_reg[CC_ISP_BIT] && !s_q.isp_mode) begin
			s_d.isp_mode    = 1'b1;
			s_d.loader_exec = 1'b1;
			s_d.wake_pulse  = 1'b1;
			s_d.first_interrupt_return_instr  = 1'b1;
		end
		if (cpu_interrupt_return_instr && s_q.first_interrupt_return_instr) begin
			s_d.first_interrupt_return_instr = 1'b0;
		end
		// flash registers
		if (wr_ok && wr_at(ADDR_FLASH_ADDR_HI)) begin
			s_d.isp_flash_addr_high = sfr_wdata;
		end
		if (wr_ok && wr_at(ADDR_FLASH_ADDR_LO)) begin
			s_d.isp_flash_addr_low = sfr_wdata;
		end
		if (wr_ok && wr_at(ADDR_FLASH_DATA)) begin
			s_d.isp_flash_data = sfr_wdata;
		end
		case (s_q.fl)
			FL_IDLE: begin
				if (wr_ok && s_q.isp_mode && wr_at(ADDR_FLASH_CONTROL)) begin
					s_d.isp_flash_control = {1'b0, sfr_wdata[6:0]};
					if (!sfr_wdata[FC_CE_BIT] && (((sfr_wdata[3:0] == OP_ERASE
						|| sfr_wdata[3:0] == OP_PROGRAM) && sfr_wdata[FC_OE_BIT])
						|| (sfr_wdata[3:0] == OP_READ && !sfr_wdata[FC_OE_BIT]))) begin
						s_d.fl       = FL_BUSY;
						s_d.start    = 1'b1;
						s_d.busy_cnt = 8'd0;
					end
				end
			end
			FL_BUSY: begin
				if (s_q.busy_cnt != 8'(BUSY_MIN)) begin
					s_d.busy_cnt = s_q.busy_cnt + 8'd1;
				end
				if (flash_done) begin
					s_d.fl = FL_IDLE;
					if (s_q.isp_flash_control[3:0] == OP_READ) begin
						s_d.isp_flash_data = flash_rdata;
					end
				end
			end
			default: s_d.fl = FL_IDLE;
		endcase
		// register read-back
		if (sfr_rd) begin
			s_d.hit = 1'b1;
			case (sfr_addr)
				ADDR_CHIP_CONTROL:  s_d.rdata = s_q.chip_control_reg;
				ADDR_FLASH_CONTROL: s_d.rdata = s_q.isp_flash_control;
				ADDR_FLASH_ADDR_HI: s_d.rdata = s_q.isp_flash_addr_high;
				ADDR_FLASH_ADDR_LO: s_d.rdata = s_q.isp_flash_addr_low;
				ADDR_FLASH_DATA:    s_d.rdata = locked ? RESET_BYTE : s_q.isp_flash_data;
				default:            s_d.hit   = 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign sfr_rdata        = s_q.rdata;
	assign sfr_hit          = s_q.hit;
	assign cpu_hold         = (s_q.fl == FL_BUSY);
	assign cpu_soft_reset   = s_q.soft_reset;
	assign cpu_fetch_loader = s_q.loader_exec;
	assign cpu_pc_clear     = s_q.wake_pulse;
	assign cpu_push_vector  = s_q.wake_pulse;
	assign cpu_vector       = LOADER_VECTOR;
	// external-fetched table reads keep out of internal code when restricted
	assign table_read_internal_ok = !fetch_external || option_bits[OPT_TRD_BIT];
	// encryption bit only clears through the off-line whole-chip erase
	assign port0_encrypt    = ~option_bits[OPT_ENC_BIT];
	assign osc_half_gain    = ~option_bits[OPT_GAIN_BIT];
	assign flash_start          = s_q.start;
	assign target_bank_select   = s_q.isp_flash_control[FC_BANK_BIT];
	assign flash_output_enable  = s_q.isp_flash_control[FC_OE_BIT];
	assign flash_chip_enable    = s_q.isp_flash_control[FC_CE_BIT];
	assign flash_op             = s_q.isp_flash_control[3:0];
	// loader bank only decodes 4 KB
	assign flash_addr = s_q.isp_flash_control[FC_BANK_BIT]
		? {4'h0, s_q.isp_flash_addr_high[3:0], s_q.isp_flash_addr_low}
		: {s_q.isp_flash_addr_high, s_q.isp_flash_addr_low};
	assign flash_wdata = s_q.isp_flash_data;
endmodule

/* ifs_flash_model.sv */
// Purpose: behavioural flash arrays answering the sequencer's flash port
// Assumes: one command at a time; answer after lat cycles (lat >= 1)
// Notes:   unwritten or erased cells read as ERASED; rdata churns when idle
`timescale 1ns/1ps
module ifs_flash_model
	import ifs_pkg::*;
#(
	parameter logic [7:0] ERASED = 8'hFF
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic        bank,
	input  wire logic  [3:0] op,
	input  wire logic [15:0] addr,
	input  wire logic  [7:0] wdata,
	input  wire logic  [7:0] lat,
	output logic       [7:0] rdata,
	output logic             done
);
	logic [7:0] mem [0:131071];
	logic [7:0] cnt;
	logic [16:0] key;
	// loader bank only decodes 12 bits
	assign key = {bank, bank ? {4'h0, addr[11:0]} : addr};
	// arrays start blank; a bench reset must not wipe non-volatile contents
	initial begin
		foreach (mem[k]) mem[k] = ERASED;
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt  <= 8'h00;
			done <= 1'b0;
			rdata <= 8'h00;
		end else begin
			done  <= 1'b0;
			rdata <= ~rdata; // no stale value between answers
			if (start) begin
				cnt <= lat;
			end else if (cnt == 8'h01) begin
				cnt  <= 8'h00;
				done <= 1'b1;
				if (op == OP_ERASE) begin
					for (int k = 0; k < 65536; k++) begin
						mem[{bank, 16'(k)}] <= ERASED;
					end
				end else if (op == OP_PROGRAM) begin
					mem[key] <= wdata;
				end else begin
					rdata <= mem[key];
				end
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

/* ifs_sequencer_assertions.sv */
// Purpose: port-level checks of the flash sequencer
// Assumes: one clock domain
// Notes:   bound into every ifs_sequencer instance
`timescale 1ns/1ps
module ifs_sequencer_chk
	import ifs_pkg::*;
#(
	parameter int unsigned BUSY_MIN = BUSY_CYCLES
) (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       flash_start,
	input wire logic       cpu_hold,
	input wire logic       flash_done,
	input wire logic [3:0] flash_op,
	input wire logic       flash_output_enable,
	input wire logic       flash_chip_enable,
	input wire logic [7:0] option_bits,
	input wire logic       osc_half_gain,
	input wire logic       fetch_external,
	input wire logic       table_read_internal_ok,
	input wire logic       cpu_pc_clear,
	input wire logic       cpu_push_vector,
	input wire logic [15:0] cpu_vector,
	input wire logic       cpu_idle_wake,
	input wire logic       cpu_soft_reset,
	input wire logic       cpu_fetch_loader
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	start_holds_a: assert property (flash_start |-> cpu_hold) else $error("start without hold");
	hold_ends_a: assert property (cpu_hold && flash_done |=> !cpu_hold) else $error("hold stuck");
	no_restart_a: assert property (flash_start |=> !flash_start) else $error("start repeated");
	erase_code_a: assert property (flash_start && flash_op == OP_ERASE
		|-> flash_output_enable && !flash_chip_enable) else $error("erase enables");
	prog_code_a: assert property (flash_start && flash_op == OP_PROGRAM
		|-> flash_output_enable && !flash_chip_enable) else $error("program enables");
	read_code_a: assert property (flash_start && flash_op == OP_READ
		|-> !flash_output_enable && !flash_chip_enable) else $error("read enables");
	lock_blocks_a: assert property (!option_bits[OPT_LOCK_BIT] [*2] |-> !flash_start)
		else $error("start while locked");
	half_gain_a: assert property (osc_half_gain == !option_bits[OPT_GAIN_BIT]) else $error("gain");
	table_rd_a: assert property (fetch_external && !option_bits[OPT_TRD_BIT]
		|-> !table_read_internal_ok) else $error("table read leak");
	wake_entry_a: assert property (cpu_pc_clear |-> cpu_push_vector && $past(cpu_idle_wake)
		&& cpu_vector == LOADER_VECTOR) else $error("entry vector");
	soft_rst_a: assert property (cpu_soft_reset |-> ##[0:2] !cpu_fetch_loader)
		else $error("soft reset kept loader");
	cover property (flash_start && flash_op == OP_ERASE);
	cover property (cpu_pc_clear);
	cover property (cpu_soft_reset);
endmodule
bind ifs_sequencer ifs_sequencer_chk #(.BUSY_MIN(BUSY_MIN)) i_chk (.clk_sys(clk_sys), .rst(rst),
	.flash_start(flash_start), .cpu_hold(cpu_hold), .flash_done(flash_done),
	.flash_op(flash_op), .flash_output_enable(flash_output_enable),
	.flash_chip_enable(flash_chip_enable), .option_bits(option_bits),
	.osc_half_gain(osc_half_gain), .fetch_external(fetch_external),
	.table_read_internal_ok(table_read_internal_ok), .cpu_pc_clear(cpu_pc_clear),
	.cpu_push_vector(cpu_push_vector), .cpu_vector(cpu_vector), .cpu_idle_wake(cpu_idle_wake),
	.cpu_soft_reset(cpu_soft_reset), .cpu_fetch_loader(cpu_fetch_loader));

/* isp_flash_sequencer_tb.sv */
// Purpose: register-level tests of the flash sequencer against a flash model
// Assumes: inputs move on the falling edge
// Notes:   writes may run back to back; idle() drops the strobes
`timescale 1ns/1ps
module isp_flash_sequencer_tb
	import ifs_pkg::*;
;
	logic clk_sys, rst, wr, rd, wake, interrupt_return_instr, sa, sb, sc, fext, hit, hold, srst, ldr, pcc, psh;
	logic start, bank, oe, ce, t_ok, enc, hg, done;
	logic [7:0] addr, wdat, rdat, opt, frd, lat;
	logic [3:0] op;
	logic [15:0] vec, fa;
	logic [7:0] fwd;
	int num_errors = 0, compares = 0, cyc = 0;
	ifs_sequencer i_dut (.clk_sys(clk_sys), .rst(rst), .sfr_addr(addr), .sfr_wr(wr),
		.sfr_rd(rd), .sfr_wdata(wdat), .sfr_rdata(rdat), .sfr_hit(hit), .cpu_idle_wake(wake),
		.cpu_interrupt_return_instr(interrupt_return_instr), .cpu_hold(hold), .cpu_soft_reset(srst), .cpu_fetch_loader(ldr),
		.cpu_pc_clear(pcc), .cpu_push_vector(psh), .cpu_vector(vec), .boot_strap_a(sa),
		.boot_strap_b(sb), .boot_strap_c(sc), .option_bits(opt), .fetch_external(fext),
		.table_read_internal_ok(t_ok), .port0_encrypt(enc), .osc_half_gain(hg),
		.flash_start(start), .target_bank_select(bank), .flash_output_enable(oe),
		.flash_chip_enable(ce), .flash_op(op), .flash_addr(fa), .flash_wdata(fwd),
		.flash_rdata(frd), .flash_done(done));
	ifs_flash_model i_mem (.clk_sys(clk_sys), .rst(rst), .start(start), .bank(bank), .op(op),
		.addr(fa), .wdata(fwd), .lat(lat), .rdata(frd), .done(done));
	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrs(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		addr = a; wdat = d; wr = 1;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk_sys);
			wr = 0; rd = 0; wake = 0;
		end
	endtask
	task automatic rds(input logic [7:0] a, input logic [7:0] exp, input logic h);
		@(negedge clk_sys);
		addr = a; rd = 1; wr = 0;
		idle(1);
		chk(rdat, exp);
		chk(hit, h);
	endtask
	task automatic unlock();
		wrs(ADDR_WRITE_UNLOCK, UNLOCK_FIRST);
		wrs(ADDR_WRITE_UNLOCK, UNLOCK_SECOND);
	endtask
	task automatic cmd(input logic [7:0] c);
		int n;
		wrs(ADDR_FLASH_CONTROL, c);
		idle(2);
		chk(hold, 1);
		for (n = 0; n < 100 && hold !== 1'b0; n++) @(negedge clk_sys);
		chk(hold, 0);
	endtask
	task automatic reset_dut(input logic [2:0] s, input logic [7:0] o);
		{sa, sb, sc} = s; opt = o; rst = 1;
		repeat (16) @(negedge clk_sys);
		rst = 0;
		idle(2);
	endtask
	task automatic complete_run();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{wr, rd, wake, interrupt_return_instr, fext, addr, wdat} = 0;
		lat = 8'h03;
		reset_dut(3'b000, 8'hCF);
		chk(ldr, 1);
		reset_dut(3'b110, 8'hDF);
		chk(ldr, 1);
		reset_dut(3'b001, 8'hFF);
		chk(ldr, 0);
		rds(8'h00, 8'h00, 0);
		wrs(ADDR_CHIP_CONTROL, 8'h01); idle(1); rds(ADDR_CHIP_CONTROL, 8'h00, 1);
		wrs(ADDR_WRITE_UNLOCK, UNLOCK_FIRST); wrs(ADDR_WRITE_UNLOCK, 8'h00);
		wrs(ADDR_CHIP_CONTROL, 8'h01); idle(1); rds(ADDR_CHIP_CONTROL, 8'h00, 1);
		wrs(ADDR_WRITE_UNLOCK, UNLOCK_FIRST); idle(3); wrs(ADDR_WRITE_UNLOCK, UNLOCK_SECOND);
		wrs(ADDR_CHIP_CONTROL, 8'h01); idle(1); rds(ADDR_CHIP_CONTROL, 8'h00, 1);
		unlock(); idle(3); wrs(ADDR_CHIP_CONTROL, 8'h01); idle(1);
		rds(ADDR_CHIP_CONTROL, 8'h00, 1);
		unlock(); wrs(ADDR_CHIP_CONTROL, 8'h01); idle(3);
		rds(ADDR_CHIP_CONTROL, 8'h01, 1);
		chk(ldr, 0);
		@(negedge clk_sys); wake = 1; idle(1);
		chk(pcc, 1);
		chk(psh, 1);
		idle(1);
		chk(ldr, 1);
		chk(vec, LOADER_VECTOR);
		wrs(ADDR_FLASH_ADDR_HI, 8'h12); wrs(ADDR_FLASH_ADDR_LO, 8'h34);
		wrs(ADDR_FLASH_DATA, 8'hA5); cmd(8'h21);
		chk(fa, 16'h1234);
		lat = 8'h09; // slow answer
		wrs(ADDR_FLASH_DATA, 8'h5A); cmd(8'h61);
		wrs(ADDR_FLASH_DATA, 8'h00); cmd(8'h00); rds(ADDR_FLASH_DATA, 8'hA5, 1);
		lat = 8'h01;
		cmd(8'h22); cmd(8'h00); rds(ADDR_FLASH_DATA, 8'hFF, 1);
		wrs(ADDR_FLASH_ADDR_HI, 8'hF2); cmd(8'h40); rds(ADDR_FLASH_DATA, 8'h5A, 1);
		opt = 8'hFE; wrs(ADDR_FLASH_CONTROL, 8'h00); idle(3);
		chk(hold, 0);
		rds(ADDR_FLASH_DATA, 8'h00, 1);
		for (int i = 0; i < 8; i++) begin
			opt = {i[2], 4'hF, ~i[1], i[0], 1'b1};
			fext = i[1];
			@(negedge clk_sys);
			chk(hg, !i[2]);
			chk(enc, i[1]);
			chk(t_ok, !(i[1] && !i[0]));
		end
		opt = 8'hFF;
		unlock(); wrs(ADDR_CHIP_CONTROL, 8'h83); idle(1);
		chk(srst, 1);
		idle(3);
		chk(ldr, 0);
		rds(ADDR_CHIP_CONTROL, 8'h00, 1);
		complete_run();
	end
endmodule
